// [rtl/crt_raster_timing.sv]
// Raster timing generator for three fixed character-display formats, AXI4-Lite control
//
// Function
// RQ1: Characters per row are 80, 32 or 80 for formats A, B, C.
// RQ2: Character rows per frame are 24, 16 or 25.
// RQ3: Active video spans 240, 192 or 300 scan lines.
// RQ4: Format C cell is 9 dots wide and 12 lines high.
// RQ5: Rate select 1 gives 60 Hz vertical timing, 0 gives 50 Hz.
// RQ6: Vertical sync starts a format and rate dependent line count after blanking start.
// RQ7: Vertical sync lasts 10 lines in A, 3 in B and C.
// RQ8: Blanking interval before video is 20/72, 68/120, 20/84 lines.
// RQ9: A scan line lasts 100, 50 or 102 character times.
// RQ10: Horizontal sync starts 0, 6 or 5 characters after horizontal blank start.
// RQ11: Horizontal sync lasts 43, 4 or 9 character times.
// RQ12: Vertical blank output ends 1, 0 or 1 lines before video.
// RQ13: Cursor enable is active on every scan line of the cursor row.
// RQ14: Only format B puts serrations on horizontal sync during vertical sync.
// RQ15: Format B serration pulses are 4 character times wide.
// RQ16: Line buffer clock is low 4 dots in A, 5 dots in B and C.
// RQ17: Horizontal sync active high in A and C, low in B.
// RQ18: Vertical sync active low in A and B, high in C.
// RQ19: Vertical blank output is active high in all formats.
// RQ20: Vertical sync changes at the start of horizontal blanking.
// RQ21: Line-in-row counter is cleared one full row before video.
// RQ22: Refresh address holds last plus one, reloads from origin three characters early.
// RQ23: Horizontal blank covers every character time after the last active one.
// RQ24: Reset clears all counters and leaves sync and blank outputs inactive.
`timescale 1ns/1ps
`include "crt_defines.svh"

module crt_raster_timing (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               hSync,
  output logic               vSync,
  output logic               vBlank,
  output logic               hBlank,
  output logic               cursorEnable,
  output logic               lineBufClk,
  output logic [3:0]         scanLine,
  output logic [11:0]        refreshAddr
);
  import crt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [3:0]  ctrl_reg;
  logic [11:0] cursor_reg;
  logic [11:0] rowOriginReg_reg;
  logic        bValid_reg;
  logic [1:0]  bResp_reg;
  logic        rValid_reg;
  logic [1:0]  rResp_reg;
  logic [31:0] rData_reg;

  wire         wrTake    = s_axi_awvalid && s_axi_wvalid && !bValid_reg;
  wire         rdTake    = s_axi_arvalid && !rValid_reg;
  wire         wrCtrl    = wrTake && (s_axi_awaddr == `CRT_CTRL_ADDR);
  wire         wrCursor  = wrTake && (s_axi_awaddr == `CRT_CURSOR_ADDR);
  wire         wrOrigin  = wrTake && (s_axi_awaddr == `CRT_ORIGIN_ADDR);
  wire         wrHit     = wrCtrl || wrCursor || wrOrigin ||
                           (s_axi_awaddr == `CRT_STATUS_ADDR);
  wire [31:0]  strbMask  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0]  ctrlMerge   = (s_axi_wdata & strbMask) | ({28'h0, ctrl_reg} & ~strbMask);
  wire [31:0]  cursorMerge = (s_axi_wdata & strbMask) | ({20'h0, cursor_reg} & ~strbMask);
  wire [31:0]  originMerge = (s_axi_wdata & strbMask) |
                             ({20'h0, rowOriginReg_reg} & ~strbMask);

  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign s_axi_arready = rdTake;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rresp   = rResp_reg;
  assign s_axi_rdata   = rData_reg;

  wire             enable   = ctrl_reg[`CRT_CTRL_EN_BIT];
  wire             rateSel  = ctrl_reg[`CRT_CTRL_RATE_BIT];
  wire [1:0]       fmtBits  = ctrl_reg[`CRT_CTRL_FMT_LSB +: 2];
  crt_format_type  fmt;
  assign fmt = crt_format_type'(fmtBits);
  // The reserved code behaves as format A so the outputs stay defined
  wire fmtB = (fmt == CRT_FMT_B);
  wire fmtC = (fmt == CRT_FMT_C);
  wire [6:0] cursorCol = cursor_reg[`CRT_CUR_COL_LSB +: 7];
  wire [4:0] cursorRow = cursor_reg[`CRT_CUR_ROW_LSB +: 5];

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg         <= `CRT_CTRL_RESET;
      cursor_reg       <= 12'h000;
      rowOriginReg_reg <= 12'h000;
    end else begin
      if (wrCtrl)
        ctrl_reg <= ctrlMerge[3:0];
      if (wrCursor)
        cursor_reg <= cursorMerge[11:0];
      if (wrOrigin)
        rowOriginReg_reg <= originMerge[11:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bValid_reg <= 1'b0;
      bResp_reg  <= `CRT_RESP_OKAY;
    end else if (wrTake) begin
      bValid_reg <= 1'b1;
      bResp_reg  <= wrHit ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-format timing selection
  wire [3:0] cellW    = fmtB ? `CRT_B_CELL_W : fmtC ? `CRT_C_CELL_W : `CRT_A_CELL_W; // RQ4
  wire [3:0] cellH    = fmtB ? `CRT_B_CELL_H : fmtC ? `CRT_C_CELL_H : `CRT_A_CELL_H; // RQ4
  wire [6:0] charsRow = fmtB ? `CRT_B_CHARS : fmtC ? `CRT_C_CHARS : `CRT_A_CHARS; // RQ1
  wire [4:0] rowsFrm  = fmtB ? `CRT_B_ROWS : fmtC ? `CRT_C_ROWS : `CRT_A_ROWS; // RQ2
  wire [8:0] actLines = fmtB ? `CRT_B_LINES : fmtC ? `CRT_C_LINES : `CRT_A_LINES; // RQ3
  wire [6:0] hTotal   = fmtB ? `CRT_B_HTOTAL : fmtC ? `CRT_C_HTOTAL : `CRT_A_HTOTAL; // RQ9
  wire [6:0] hsDelay  = fmtB ? `CRT_B_HS_DLY : fmtC ? `CRT_C_HS_DLY : `CRT_A_HS_DLY; // RQ10
  wire [6:0] hsWidth  = fmtB ? `CRT_B_HS_W : fmtC ? `CRT_C_HS_W : `CRT_A_HS_W; // RQ11
  wire [8:0] vsWidth  = fmtB ? `CRT_B_VS_W : fmtC ? `CRT_C_VS_W : `CRT_A_VS_W; // RQ7
  wire [8:0] vbStop   = fmtB ? `CRT_B_VB_STOP : fmtC ? `CRT_C_VB_STOP : `CRT_A_VB_STOP; // RQ12
  wire [3:0] lbLow    = fmtB ? `CRT_B_LB_LOW : fmtC ? `CRT_C_LB_LOW : `CRT_A_LB_LOW; // RQ16
  wire [8:0] vsDly60  = fmtB ? `CRT_B_VS_DLY60 : fmtC ? `CRT_C_VS_DLY60 : `CRT_A_VS_DLY60;
  wire [8:0] vsDly50  = fmtB ? `CRT_B_VS_DLY50 : fmtC ? `CRT_C_VS_DLY50 : `CRT_A_VS_DLY50;
  wire [8:0] vb60     = fmtB ? `CRT_B_VB60 : fmtC ? `CRT_C_VB60 : `CRT_A_VB60;
  wire [8:0] vb50     = fmtB ? `CRT_B_VB50 : fmtC ? `CRT_C_VB50 : `CRT_A_VB50;
  wire [8:0] vsDelay  = rateSel ? vsDly60 : vsDly50; // RQ5 RQ6
  wire [8:0] vbInt    = rateSel ? vb60 : vb50; // RQ5 RQ8
  wire [8:0] vTotal   = actLines + vbInt;
  wire       hsPolHi  = !fmtB; // RQ17
  wire       vsPolHi  = fmtC; // RQ18

  ////////////////////////////////////////////////////////////////////////////////
  // Dot, character, line and row counters
  logic [3:0] dotCnt_reg;
  logic [6:0] charCnt_reg;
  logic [8:0] lineCnt_reg;
  logic [3:0] rowLine_reg;
  logic [4:0] rowCnt_reg;

  wire       charEnd   = (dotCnt_reg == cellW - 4'h1);
  wire       lineEnd   = charEnd && (charCnt_reg == hTotal - 7'h01);
  wire       frameEnd  = lineEnd && (lineCnt_reg == vTotal - 9'h001);
  wire       rowEnd    = (rowLine_reg == cellH - 4'h1);
  // One full row ahead of video, so rows stay aligned whatever the blank count
  wire [8:0] clearLine = vTotal - {5'h00, cellH} - 9'h001;
  wire       videoLine = (lineCnt_reg < actLines);

  always_ff @(posedge clock) begin
    if (rst || !enable) begin // RQ24
      dotCnt_reg  <= 4'h0;
      charCnt_reg <= 7'h00;
      lineCnt_reg <= 9'h000;
      rowLine_reg <= 4'h0;
      rowCnt_reg  <= 5'h00;
    end else begin
      dotCnt_reg <= charEnd ? 4'h0 : dotCnt_reg + 4'h1;
      if (charEnd)
        charCnt_reg <= lineEnd ? 7'h00 : charCnt_reg + 7'h01;
      if (lineEnd) begin
        lineCnt_reg <= frameEnd ? 9'h000 : lineCnt_reg + 9'h001;
        if (frameEnd || rowEnd || lineCnt_reg == clearLine) // RQ21
          rowLine_reg <= 4'h0;
        else
          rowLine_reg <= rowLine_reg + 4'h1;
        if (frameEnd)
          rowCnt_reg <= 5'h00;
        else if (rowEnd && videoLine && rowCnt_reg != rowsFrm)
          rowCnt_reg <= rowCnt_reg + 5'h01; // RQ2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Horizontal and vertical decode
  wire [7:0] hsStartRaw = {1'b0, charsRow} + {1'b0, hsDelay};
  wire [6:0] hsStart    = (hsStartRaw >= {1'b0, hTotal}) ?
                          7'(hsStartRaw - {1'b0, hTotal}) : hsStartRaw[6:0];
  // Distance from sync start, folded so a pulse may wrap into the next line
  wire [6:0] hsDist     = (charCnt_reg >= hsStart) ? charCnt_reg - hsStart
                                                   : charCnt_reg + hTotal - hsStart;
  wire       inHsPulse  = (hsDist < hsWidth); // RQ10 RQ11
  wire       inSerrNotch = (hsDist < `CRT_B_SERR_W); // RQ15
  wire       activeChar = (charCnt_reg < charsRow);
  wire       hBlankAct  = !activeChar; // RQ23
  wire [8:0] vsStart    = actLines + vsDelay;
  wire       vsLineAct  = (lineCnt_reg >= vsStart) && (lineCnt_reg < vsStart + vsWidth); // RQ6 RQ7
  wire       vbAct      = !videoLine && (lineCnt_reg < vTotal - vbStop); // RQ8 RQ12
  wire       hblankEdge = charEnd && (charCnt_reg == charsRow - 7'h01);

  logic vsAct_reg;
  // Inverted sync with a notch gives composite-style serrations in format B
  wire  hsAct = (vsAct_reg && fmtB) ? !inSerrNotch : inHsPulse; // RQ14
  wire  curAct = videoLine && activeChar && (rowCnt_reg == cursorRow) &&
                 (charCnt_reg == cursorCol); // RQ13

  always_ff @(posedge clock) begin
    if (rst || !enable)
      vsAct_reg <= 1'b0;
    else if (hblankEdge)
      vsAct_reg <= vsLineAct; // RQ20
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic        hSync_reg;
  logic        vSync_reg;
  logic        vBlank_reg;
  logic        hBlank_reg;
  logic        cursor_en_reg;
  logic        lineBufClk_reg;
  logic [11:0] refreshAddr_reg;

  always_ff @(posedge clock) begin
    if (rst) begin // RQ24
      hSync_reg      <= 1'b0;
      vSync_reg      <= 1'b1;
      vBlank_reg     <= 1'b0;
      hBlank_reg     <= 1'b0;
      cursor_en_reg  <= 1'b0;
      lineBufClk_reg <= 1'b1;
    end else if (!enable) begin // RQ24
      hSync_reg      <= !hsPolHi;
      vSync_reg      <= !vsPolHi;
      vBlank_reg     <= 1'b0;
      hBlank_reg     <= 1'b0;
      cursor_en_reg  <= 1'b0;
      lineBufClk_reg <= 1'b1;
    end else begin
      hSync_reg      <= hsPolHi ? hsAct : !hsAct; // RQ17
      vSync_reg      <= vsPolHi ? vsAct_reg : !vsAct_reg; // RQ18
      vBlank_reg     <= vbAct; // RQ19
      hBlank_reg     <= hBlankAct;
      cursor_en_reg  <= curAct;
      lineBufClk_reg <= !(dotCnt_reg < lbLow); // RQ16
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      refreshAddr_reg <= 12'h000;
    else if (charEnd && charCnt_reg == hTotal - `CRT_RELOAD_LEAD)
      refreshAddr_reg <= rowOriginReg_reg; // RQ22
    else if (charEnd && activeChar && enable)
      refreshAddr_reg <= refreshAddr_reg + 12'h001; // RQ22
  end

  assign hSync        = hSync_reg;
  assign vSync        = vSync_reg;
  assign vBlank       = vBlank_reg;
  assign hBlank       = hBlank_reg;
  assign cursorEnable = cursor_en_reg;
  assign lineBufClk   = lineBufClk_reg;
  assign scanLine     = rowLine_reg;
  assign refreshAddr  = refreshAddr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [31:0] statusWord = {2'h0, vsAct_reg, vbAct, 3'h0, lineCnt_reg,
                            1'b0, charCnt_reg, 3'h0, rowCnt_reg};
  wire        rdCtrl   = (s_axi_araddr == `CRT_CTRL_ADDR);
  wire        rdCursor = (s_axi_araddr == `CRT_CURSOR_ADDR);
  wire        rdOrigin = (s_axi_araddr == `CRT_ORIGIN_ADDR);
  wire        rdStatus = (s_axi_araddr == `CRT_STATUS_ADDR);
  wire        rdHit    = rdCtrl || rdCursor || rdOrigin || rdStatus;
  wire [31:0] rdMux    = rdCtrl   ? {28'h0, ctrl_reg} :
                         rdCursor ? {20'h0, cursor_reg} :
                         rdOrigin ? {20'h0, rowOriginReg_reg} :
                         rdStatus ? statusWord : 32'h0;

  always_ff @(posedge clock) begin
    if (rst) begin
      rValid_reg <= 1'b0;
      rResp_reg  <= `CRT_RESP_OKAY;
      rData_reg  <= 32'h0;
    end else if (rdTake) begin
      rValid_reg <= 1'b1;
      rResp_reg  <= rdHit ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
      rData_reg  <= rdMux;
    end else if (s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end

endmodule

// [rtl/crt_defines.svh]
// Register map, field positions, reset values and per-format raster constants
`ifndef CRT_DEFINES_SVH
`define CRT_DEFINES_SVH

`define CRT_CTRL_ADDR        8'h00
`define CRT_CURSOR_ADDR      8'h04
`define CRT_ORIGIN_ADDR      8'h08
`define CRT_STATUS_ADDR      8'h0C
`define CRT_CTRL_EN_BIT      0
`define CRT_CTRL_FMT_LSB     1
`define CRT_CTRL_RATE_BIT    3
`define CRT_CUR_COL_LSB      0
`define CRT_CUR_ROW_LSB      8
`define CRT_CTRL_RESET       4'h8
`define CRT_RESP_OKAY        2'h0
`define CRT_RESP_SLVERR      2'h2

// Format A
`define CRT_A_CELL_W   4'h7
`define CRT_A_CELL_H   4'hA
`define CRT_A_CHARS    7'h50
`define CRT_A_ROWS     5'h18
`define CRT_A_LINES    9'h0F0
`define CRT_A_HTOTAL   7'h64
`define CRT_A_HS_DLY   7'h00
`define CRT_A_HS_W     7'h2B
`define CRT_A_VS_DLY60 9'h004
`define CRT_A_VS_DLY50 9'h01E
`define CRT_A_VS_W     9'h00A
`define CRT_A_VB60     9'h014
`define CRT_A_VB50     9'h048
`define CRT_A_VB_STOP  9'h001
`define CRT_A_LB_LOW   4'h4
// Format B
`define CRT_B_CELL_W   4'h9
`define CRT_B_CELL_H   4'hC
`define CRT_B_CHARS    7'h20
`define CRT_B_ROWS     5'h10
`define CRT_B_LINES    9'h0C0
`define CRT_B_HTOTAL   7'h32
`define CRT_B_HS_DLY   7'h06
`define CRT_B_HS_W     7'h04
`define CRT_B_VS_DLY60 9'h01B
`define CRT_B_VS_DLY50 9'h035
`define CRT_B_VS_W     9'h003
`define CRT_B_VB60     9'h044
`define CRT_B_VB50     9'h078
`define CRT_B_VB_STOP  9'h000
`define CRT_B_LB_LOW   4'h5
`define CRT_B_SERR_W   7'h04
// Format C
`define CRT_C_CELL_W   4'h9
`define CRT_C_CELL_H   4'hC
`define CRT_C_CHARS    7'h50
`define CRT_C_ROWS     5'h19
`define CRT_C_LINES    9'h12C
`define CRT_C_HTOTAL   7'h66
`define CRT_C_HS_DLY   7'h05
`define CRT_C_HS_W     7'h09
`define CRT_C_VS_DLY60 9'h000
`define CRT_C_VS_DLY50 9'h020
`define CRT_C_VS_W     9'h003
`define CRT_C_VB60     9'h014
`define CRT_C_VB50     9'h054
`define CRT_C_VB_STOP  9'h001
`define CRT_C_LB_LOW   4'h5
// Refresh address reload lead, in character times
`define CRT_RELOAD_LEAD 7'h03

`endif

// [rtl/crt_pkg.sv]
// Types shared by the raster timing block
package crt_pkg;
  typedef enum logic [1:0] {
    CRT_FMT_A,
    CRT_FMT_B,
    CRT_FMT_C,
    CRT_FMT_RSVD
  } crt_format_type;
endpackage

// [bench/crt_raster_timing_assertions.sv]
// Port-level protocol and raster checks for the timing block
`timescale 1ns/1ps
module crt_raster_timing_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        hBlank,
  input wire logic        lineBufClk
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic wrTake;
  logic rdTake;
  assign wrTake = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  assign rdTake = s_axi_arvalid && s_axi_arready;
  ////////////////////////////////////////
  write_answer_a: assert property (wrTake |=> s_axi_bvalid &&
    s_axi_bresp == (($past(s_axi_awaddr) > 8'h0C) ? 2'h2 : 2'h0)) else $error("bad write answer");
  read_answer_a: assert property (rdTake |=> s_axi_rvalid) else $error("read answer late");
  read_unmapped_a: assert property (rdTake && s_axi_araddr > 8'h0C |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answer wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken");
  lbclk_low_a: assert property ($fell(lineBufClk) |-> !lineBufClk[*4] ##[1:2] lineBufClk)
    else $error("line buffer clock low time wrong");
  hblank_span_a: assert property ($rose(hBlank) |-> hBlank[*8])
    else $error("horizontal blank too short");
  cover property (wrTake);
  cover property (s_axi_bvalid && !s_axi_bready);
  cover property (rdTake && s_axi_araddr > 8'h0C);
  cover property ($rose(hBlank));
endmodule
bind crt_raster_timing crt_raster_timing_assertions chk_u (.*);

// [bench/crt_video_monitor.sv]
// Monitor model: measures one span of a scan line, from one blank start to the next
`timescale 1ns/1ps
module crt_video_monitor (
  input wire logic clock,
  input wire logic hSync,
  input wire logic hBlank,
  input wire logic lineBufClk,
  input wire logic cursorEnable,
  input wire logic syncLevel,
  output int       lineLen,
  output int       blankLen,
  output int       syncLen,
  output int       lowLen,
  output int       curLen,
  output int       lineCount
);
  int   lAcc = 0;
  int   bAcc = 0;
  int   sAcc = 0;
  int   wAcc = 0;
  int   cAcc = 0;
  logic hbPrev = 1'b0;
  initial lineCount = 0;
  // Spans start at blank start so a wrapping sync pulse is counted whole
  always @(posedge clock) begin
    hbPrev <= hBlank;
    if (hBlank && !hbPrev) begin
      lineLen <= lAcc;
      blankLen <= bAcc;
      syncLen <= sAcc;
      lowLen <= wAcc;
      curLen <= cAcc;
      lineCount <= lineCount + 1;
      lAcc <= 1;
      bAcc <= 1;
      sAcc <= int'(hSync == syncLevel);
      wAcc <= int'(!lineBufClk);
      cAcc <= int'(cursorEnable);
    end else begin
      lAcc <= lAcc + 1;
      bAcc <= bAcc + int'(hBlank);
      sAcc <= sAcc + int'(hSync == syncLevel);
      wAcc <= wAcc + int'(!lineBufClk);
      cAcc <= cAcc + int'(cursorEnable);
    end
  end
endmodule

// [bench/crt_raster_timing_test.sv]
// Self-checking bench: register access and horizontal raster timing per format
`timescale 1ns/1ps
module crt_raster_timing_test;
  localparam int   HT [3]  = '{100, 50, 102};
  localparam int   CH [3]  = '{80, 32, 80};
  localparam int   CW [3]  = '{7, 9, 9};
  localparam int   HSW [3] = '{43, 4, 9};
  localparam int   LBL [3] = '{4, 5, 5};
  localparam logic HSA [3] = '{1'b1, 1'b0, 1'b1};
  localparam logic VSI [3] = '{1'b1, 1'b1, 1'b0};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic hSync, vSync, vBlank, hBlank, cursorEnable, lineBufClk;
  logic [3:0] scanLine;
  logic [11:0] refreshAddr;
  logic hAct = 1'b1;
  int lineLen, blankLen, syncLen, lowLen, curLen, lineCount;
  int miscompares = 0;
  int checkCount = 0;
  int seed = 32'h0025847f;
  always #2 clock = ~clock;
  crt_raster_timing dut_u (.*);
  crt_video_monitor mon_u (.clock(clock), .hSync(hSync), .hBlank(hBlank),
    .lineBufClk(lineBufClk), .cursorEnable(cursorEnable), .syncLevel(hAct),
    .lineLen(lineLen), .blankLen(blankLen), .syncLen(syncLen), .lowLen(lowLen),
    .curLen(curLen), .lineCount(lineCount));
  ////////////////////////////////////////
  function automatic int dots(input int f, input int n);
    return n * CW[f];
  endfunction
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic bounded(input int i, input int lim);
    if (i >= lim) begin
      miscompares++;
      conclude();
    end
  endtask
  // Response ready raised a cycle late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    i = 0;
    do begin @(posedge clock); i++; end while (!s_axi_awready && i < 50);
    bounded(i, 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge clock);
    s_axi_bready <= 1'b1;
    do begin @(posedge clock); i++; end while (!s_axi_bvalid && i < 100);
    bounded(i, 100);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    i = 0;
    do begin @(posedge clock); i++; end while (!s_axi_arready && i < 50);
    bounded(i, 50);
    s_axi_arvalid <= 1'b0;
    @(posedge clock);
    s_axi_rready <= 1'b1;
    do begin @(posedge clock); i++; end while (!s_axi_rvalid && i < 100);
    bounded(i, 100);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  ////////////////////////////////////////
  initial begin
    int f;
    int i;
    int k;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
    logic [6:0] col;
    logic [11:0] org;
    logic rate;
    repeat (4) @(posedge clock);
    chk("hSync", 32'h0, {31'h0, hSync});
    chk("vSync", 32'h1, {31'h0, vSync});
    chk("blank", 32'h0, {30'h0, hBlank, vBlank});
    rst <= 1'b0;
    @(posedge clock);
    rd(8'h00, d, r);
    chk("ctrl", 32'h8, d);
    rd(8'h10, d, r);
    chk("unmappedResp", 32'h2, {30'h0, r});
    chk("unmappedData", 32'h0, d);
    wr(8'h14, $random(seed), 2'h2);
    for (k = 0; k < 3; k++) begin
      d = $random(seed);
      wr(8'h08, d, 2'h0);
      rd(8'h08, q, r);
      chk("origin", {20'h0, d[11:0]}, q);
      org = d[11:0];
    end
    for (f = 0; f < 3; f++) begin
      rate = 1'($random(seed));
      col = 7'($unsigned($random(seed)) % CH[f]);
      hAct <= HSA[f];
      wr(8'h04, {25'h0, col}, 2'h0);
      wr(8'h00, {28'h0, rate, 2'(f), 1'b1}, 2'h0);
      k = lineCount + 3;
      for (i = 0; i < 4000 && lineCount < k; i++) @(posedge clock);
      bounded(i, 4000);
      chk("lineLen", dots(f, HT[f]), lineLen);
      chk("blankLen", dots(f, HT[f] - CH[f]), blankLen);
      chk("syncLen", dots(f, HSW[f]), syncLen);
      chk("lowLen", LBL[f] * HT[f], lowLen);
      chk("curLen", dots(f, 1), curLen);
      chk("vSync", {31'h0, VSI[f]}, {31'h0, vSync});
      chk("vBlank", 32'h0, {31'h0, vBlank});
      chk("scanLine", 32'h2, {28'h0, scanLine});
      chk("refreshAddr", {20'h0, 12'(org + 12'(CH[f]))}, {20'h0, refreshAddr});
      wr(8'h00, 32'h0, 2'h0);
    end
    conclude();
  end
endmodule
